// ===== rtl/srd_defines.vh
// Constants for the state register read decoder
`ifndef SRD_DEFINES_VH
`define SRD_DEFINES_VH
`define SRD_SEL_MULHI 5'h00
`define SRD_SEL_CCR 5'h02
`define SRD_SEL_ASI 5'h03
`define SRD_SEL_CYC 5'h04
`define SRD_SEL_PC 5'h05
`define SRD_SEL_FPRS 5'h06
`define SRD_SEL_BAR 5'h0F
`define SRD_SEL_PCTL 5'h10
`define SRD_SEL_PCNT 5'h11
`define SRD_SEL_GSR 5'h13
`define SRD_SEL_SINT 5'h16
`define SRD_SEL_CCMP 5'h17
`define SRD_SEL_SYS 5'h18
`define SRD_SEL_SCMP 5'h19
`define SRD_SEL_TPC 5'h00
`define SRD_SEL_TRAP_SAVED_NEXT_PC 5'h01
`define SRD_SEL_TRAP_SAVED_STATE 5'h02
`define SRD_SEL_TT 5'h03
`define SRD_SEL_PR_LAST 5'h10
`define SRD_EXC_NONE 3'h0
`define SRD_EXC_ILLEGAL 3'h1
`define SRD_EXC_PRIV_OPC 3'h2
`define SRD_EXC_FP_OFF 3'h3
`define SRD_EXC_PRIV_ACT 3'h4
`define SRD_ADDR_CTRL 8'h00
`define SRD_ADDR_STAT 8'h04
`define SRD_ADDR_MASK 8'h08
`define SRD_ADDR_COUNT 8'h0C
`define SRD_CTRL_RESET 32'h00000001
`endif

// ===== rtl/srd_state_read.v
// State register read decoder with AXI4-Lite control and interrupt registers
//
// Summary of operation
// [RQ1] Ancillary read copies the selected state register into the destination register.
// [RQ2] Select 0 multiply-high, 2 condition codes, 3 address space identifier.
// [RQ3] Select 4 cycle counter, 5 program counter, 6 fp register status.
// [RQ4] Select 16 perf control, 17 perf counters, 19 graphics status.
// [RQ5] Select 22 soft interrupt, 23 cycle compare, 24 system counter, 25 system compare.
// [RQ6] Program counter read zeroes upper half when 32-bit address mask is set.
// [RQ7] Floating status read waits until all pending fp operations finish.
// [RQ8] Reserved selects 1, 7-14, 18, 20-21, 26-27 are illegal.
// [RQ9] Select 15 with zero destination is memory barrier, else illegal.
// [RQ10] Nonzero instruction bits 13:0 make either read illegal, except an ancillary read of select 15.
// [RQ11] Selects 28-31 behave per implementation: here configurable illegal and privileged.
// [RQ12] Nonprivileged reads of perf control, soft interrupt, compare registers are privileged opcode.
// [RQ13] Graphics status read with fpu_off_exception or absent raises fpu_off_exception.
// [RQ14] User counter reads raise privileged action when user access is disabled.
// [RQ15] Trap-stack registers have one copy per trap level, read by current level.
// [RQ16] Privileged read with select 15 or 17-31 is illegal.
// [RQ17] Privileged mode trap level zero reads of selects 0-3 are illegal.
// [RQ18] Privileged read in user mode is privileged opcode, over trap-level-zero illegal.
// [RQ19] Destination is written only when the read completes without exception.
`timescale 1ns/1ps
`include "srd_defines.vh"
module srd_state_read #(
    parameter LEVELS = 2,
    parameter LW = 3
) (
    input wire i_clock,
    input wire i_rstn,
    // Instruction issue
    input wire i_valid,
    input wire i_is_priv_read,
    input wire [31:0] i_instr,
    output wire o_ready,
    // Machine state
    input wire i_priv,
    input wire i_addr_mask_32_bit,
    input wire i_fp_enable_pstate,
    input wire i_fp_enable_fprs,
    input wire i_fpu_present,
    input wire i_fp_busy,
    input wire i_cycle_user_off,
    input wire i_system_user_off,
    input wire i_perf_ctl_priv,
    input wire [LW-1:0] i_trap_level,
    // Source values
    input wire [63:0] i_mulhi,
    input wire [63:0] i_ccr,
    input wire [63:0] i_asi,
    input wire [63:0] i_cycle,
    input wire [63:0] i_pc,
    input wire [63:0] i_fprs,
    input wire [63:0] i_perf_ctl,
    input wire [63:0] i_perf_cnt,
    input wire [63:0] i_gsr,
    input wire [63:0] i_soft_int,
    input wire [63:0] i_cycle_compare_reg,
    input wire [63:0] i_system,
    input wire [63:0] i_system_compare_reg,
    input wire [63:0] i_pr_other,
    // Trap-stack update from trap logic
    input wire i_trap_wr,
    input wire [LW-1:0] i_trap_wr_level,
    input wire [63:0] i_trap_saved_pc,
    input wire [63:0] i_trap_saved_next_pc,
    input wire [63:0] i_trap_saved_state,
    input wire [63:0] i_trap_type_reg,
    // Results
    output reg o_wb_en,
    output reg [4:0] o_wb_reg,
    output reg [63:0] o_wb_data,
    output reg o_barrier,
    output reg [2:0] o_exception,
    output wire o_irq,
    // AXI4-Lite slave
    input wire [7:0] i_awaddr,
    input wire i_awvalid,
    output wire o_awready,
    input wire [31:0] i_wdata,
    input wire [3:0] i_wstrb,
    input wire i_wvalid,
    output wire o_wready,
    output reg [1:0] o_bresp,
    output reg o_bvalid,
    input wire i_bready,
    input wire [7:0] i_araddr,
    input wire i_arvalid,
    output wire o_arready,
    output reg [31:0] o_rdata,
    output reg [1:0] o_rresp,
    output reg o_rvalid,
    input wire i_rready
);
    localparam ADDR_CTRL = `SRD_ADDR_CTRL;
    localparam ADDR_STAT = `SRD_ADDR_STAT;
    localparam ADDR_MASK = `SRD_ADDR_MASK;
    localparam ADDR_COUNT = `SRD_ADDR_COUNT;
    localparam ST_IDLE = 2'b01;
    localparam ST_WAIT = 2'b10;

    ////////////////////////////////////////////////////////////////////////////////
    // Instruction fields
    wire [4:0] dest = i_instr[29:25];
    wire [4:0] sel = i_instr[18:14];
    wire low_nz = |i_instr[13:0];
    wire [63:0] tpc_v;
    wire [63:0] trap_saved_next_pc_v;
    wire [63:0] tst_v;
    wire [63:0] tt_v;
    reg [1:0] state_q;
    reg [31:0] ctrl_q;
    reg [3:0] stat_q;
    reg [3:0] mask_q;
    reg [15:0] count_q;

    // Trap-stack copies per level
    srd_trap_stack #(.WIDTH(64), .LEVELS(LEVELS), .LW(LW)) u_tpc (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_wr_en(i_trap_wr),
        .i_wr_level(i_trap_wr_level), .i_wr_data(i_trap_saved_pc),
        .i_rd_level(i_trap_level), .o_rd_data(tpc_v)); // [RQ15]
    srd_trap_stack #(.WIDTH(64), .LEVELS(LEVELS), .LW(LW)) u_trap_saved_next_pc (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_wr_en(i_trap_wr),
        .i_wr_level(i_trap_wr_level), .i_wr_data(i_trap_saved_next_pc),
        .i_rd_level(i_trap_level), .o_rd_data(trap_saved_next_pc_v)); // [RQ15]
    srd_trap_stack #(.WIDTH(64), .LEVELS(LEVELS), .LW(LW)) u_tst (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_wr_en(i_trap_wr),
        .i_wr_level(i_trap_wr_level), .i_wr_data(i_trap_saved_state),
        .i_rd_level(i_trap_level), .o_rd_data(tst_v)); // [RQ15]
    srd_trap_stack #(.WIDTH(64), .LEVELS(LEVELS), .LW(LW)) u_tt (
        .i_clock(i_clock), .i_rstn(i_rstn), .i_wr_en(i_trap_wr),
        .i_wr_level(i_trap_wr_level), .i_wr_data(i_trap_type_reg),
        .i_rd_level(i_trap_level), .o_rd_data(tt_v)); // [RQ15]

    ////////////////////////////////////////////////////////////////////////////////
    // Decode and checks
    // Ancillary selects held back for future use
    wire anc_reserved = sel == 5'h01 || (sel >= 5'h07 && sel <= 5'h0E) || sel == 5'h12 ||
                        sel == 5'h14 || sel == 5'h15 || sel == 5'h1A || sel == 5'h1B; // [RQ8]
    // Ancillary registers only privileged code may read
    wire anc_priv_only = sel == `SRD_SEL_PCTL || sel == `SRD_SEL_SINT ||
                         sel == `SRD_SEL_CCMP || sel == `SRD_SEL_SCMP; // [RQ12]
    // Graphics status needs the fp unit present and enabled in both places
    wire fp_off = !i_fp_enable_fprs || !i_fp_enable_pstate || !i_fpu_present; // [RQ13]
    // Counters whose user access is switched off
    wire user_cnt_off = (sel == `SRD_SEL_CYC && i_cycle_user_off) ||
                        (sel == `SRD_SEL_SYS && i_system_user_off) ||
                        (sel == `SRD_SEL_PCNT && i_perf_ctl_priv); // [RQ14]

    reg [2:0] exc;
    reg [63:0] val;
    reg barrier;
    always @* begin
        exc = `SRD_EXC_NONE;
        val = 64'h0000000000000000;
        barrier = 1'b0;
        if (i_is_priv_read) begin
            if (!i_priv) begin
                exc = `SRD_EXC_PRIV_OPC; // [RQ18]
            end else if (low_nz) begin
                exc = `SRD_EXC_ILLEGAL; // [RQ10]
            end else if (sel == `SRD_SEL_BAR || sel > `SRD_SEL_PR_LAST) begin
                exc = `SRD_EXC_ILLEGAL; // [RQ16]
            end else if (sel <= `SRD_SEL_TT && i_trap_level == {LW{1'b0}}) begin
                exc = `SRD_EXC_ILLEGAL; // [RQ17]
            end
            case (sel)
                `SRD_SEL_TPC: val = tpc_v; // [RQ15]
                `SRD_SEL_TRAP_SAVED_NEXT_PC: val = trap_saved_next_pc_v;
                `SRD_SEL_TRAP_SAVED_STATE: val = tst_v;
                `SRD_SEL_TT: val = tt_v;
                default: val = i_pr_other;
            endcase
        end else begin
            case (sel)
                `SRD_SEL_MULHI: val = i_mulhi; // [RQ2]
                `SRD_SEL_CCR: val = i_ccr; // [RQ2]
                `SRD_SEL_ASI: val = i_asi; // [RQ2]
                `SRD_SEL_CYC: val = i_cycle; // [RQ3]
                `SRD_SEL_PC: val = i_addr_mask_32_bit ? {32'h00000000, i_pc[31:0]} : i_pc; // [RQ6]
                `SRD_SEL_FPRS: val = i_fprs; // [RQ3]
                `SRD_SEL_PCTL: val = i_perf_ctl; // [RQ4]
                `SRD_SEL_PCNT: val = i_perf_cnt; // [RQ4]
                `SRD_SEL_GSR: val = i_gsr; // [RQ4]
                `SRD_SEL_SINT: val = i_soft_int; // [RQ5]
                `SRD_SEL_CCMP: val = i_cycle_compare_reg; // [RQ5]
                `SRD_SEL_SYS: val = i_system; // [RQ5]
                `SRD_SEL_SCMP: val = i_system_compare_reg; // [RQ5]
                default: val = 64'h0000000000000000;
            endcase
            if (sel == `SRD_SEL_BAR) begin
                if (dest != 5'h00) begin
                    exc = `SRD_EXC_ILLEGAL; // [RQ9]
                end else begin
                    barrier = 1'b1; // [RQ9]
                end
            end else if (low_nz) begin
                exc = `SRD_EXC_ILLEGAL; // [RQ10]
            end else if (anc_reserved) begin
                exc = `SRD_EXC_ILLEGAL; // [RQ8]
            end else if (sel >= 5'h1C) begin
                if (ctrl_q[1]) begin
                    exc = `SRD_EXC_ILLEGAL; // [RQ11]
                end else if (!i_priv && ctrl_q[2]) begin
                    exc = `SRD_EXC_PRIV_OPC; // [RQ11]
                end
            end else if (!i_priv && anc_priv_only) begin
                exc = `SRD_EXC_PRIV_OPC; // [RQ12]
            end else if (sel == `SRD_SEL_GSR && fp_off) begin
                exc = `SRD_EXC_FP_OFF; // [RQ13]
            end else if (!i_priv && user_cnt_off) begin
                exc = `SRD_EXC_PRIV_ACT; // [RQ14]
            end
        end
    end

    // Floating status read stalls while fp operations are pending
    wire fp_wait = !i_is_priv_read && sel == `SRD_SEL_FPRS && i_fp_busy; // [RQ7]
    assign o_ready = ctrl_q[0] && !(fp_wait && exc == `SRD_EXC_NONE); // [RQ7]
    wire fire = i_valid && o_ready;

    ////////////////////////////////////////////////////////////////////////////////
    // Result registers and state
    always @(posedge i_clock) begin
        if (!i_rstn) begin
            state_q <= ST_IDLE;
            o_wb_en <= 1'b0;
            o_wb_reg <= 5'h00;
            o_wb_data <= 64'h0000000000000000;
            o_barrier <= 1'b0;
            o_exception <= `SRD_EXC_NONE;
            count_q <= 16'h0000;
        end else begin
            o_wb_en <= 1'b0;
            o_barrier <= 1'b0;
            o_exception <= `SRD_EXC_NONE;
            case (state_q)
                ST_IDLE: begin
                    if (i_valid && !o_ready && ctrl_q[0]) begin
                        state_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (fire || !i_valid) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
            if (fire) begin
                o_exception <= exc;
                o_barrier <= barrier && exc == `SRD_EXC_NONE;
                o_wb_en <= exc == `SRD_EXC_NONE && !barrier; // [RQ19]
                o_wb_reg <= dest; // [RQ1]
                if (exc == `SRD_EXC_NONE && !barrier) begin
                    o_wb_data <= val; // [RQ1]
                    count_q <= count_q + 16'h0001;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Interrupt status: 0 illegal, 1 privileged opcode, 2 fp off, 3 privileged action
    wire [3:0] ev = {4{fire}} & {exc == `SRD_EXC_PRIV_ACT, exc == `SRD_EXC_FP_OFF,
                                 exc == `SRD_EXC_PRIV_OPC, exc == `SRD_EXC_ILLEGAL};
    assign o_irq = |(stat_q & mask_q);

    ////////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    reg aw_q;
    reg w_q;
    reg [7:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    assign o_awready = !aw_q && !o_bvalid;
    assign o_wready = !w_q && !o_bvalid;
    assign o_arready = !o_rvalid;
    wire do_wr = aw_q && w_q && !o_bvalid;
    wire [3:0] clr = (do_wr && awaddr_q == ADDR_STAT && wstrb_q[0]) ? wdata_q[3:0] : 4'h0;

    always @(posedge i_clock) begin
        if (!i_rstn) begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            o_bvalid <= 1'b0;
            o_bresp <= 2'b00;
            o_rvalid <= 1'b0;
            o_rresp <= 2'b00;
            o_rdata <= 32'h00000000;
            ctrl_q <= `SRD_CTRL_RESET;
            mask_q <= 4'h0;
            stat_q <= 4'h0;
        end else begin
            stat_q <= (stat_q & ~clr) | ev;
            if (i_awvalid && o_awready) begin
                aw_q <= 1'b1;
                awaddr_q <= i_awaddr;
            end
            if (i_wvalid && o_wready) begin
                w_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
            end
            if (do_wr) begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= 2'b00;
                if (awaddr_q == ADDR_CTRL && wstrb_q[0]) begin
                    ctrl_q <= {29'h00000000, wdata_q[2:0]};
                end else if (awaddr_q == ADDR_MASK && wstrb_q[0]) begin
                    mask_q <= wdata_q[3:0];
                end else if (awaddr_q != ADDR_STAT && awaddr_q != ADDR_CTRL &&
                             awaddr_q != ADDR_MASK && awaddr_q != ADDR_COUNT) begin
                    o_bresp <= 2'b10;
                end
            end else if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
            end
            if (i_arvalid && o_arready) begin
                o_rvalid <= 1'b1;
                o_rresp <= 2'b00;
                case (i_araddr)
                    ADDR_CTRL: o_rdata <= ctrl_q;
                    ADDR_STAT: o_rdata <= {28'h0000000, stat_q};
                    ADDR_MASK: o_rdata <= {28'h0000000, mask_q};
                    ADDR_COUNT: o_rdata <= {14'h0000, state_q, count_q};
                    default: begin
                        o_rdata <= 32'h00000000;
                        o_rresp <= 2'b10;
                    end
                endcase
            end else if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
            end
        end
    end
endmodule // srd_state_read

// ===== rtl/srd_trap_stack.v
// One trap-stack register held per trap level
`timescale 1ns/1ps
module srd_trap_stack #(
    parameter WIDTH = 64,
    parameter LEVELS = 2,
    parameter LW = 3
) (
    input wire i_clock,
    input wire i_rstn,
    input wire i_wr_en,
    input wire [LW-1:0] i_wr_level,
    input wire [WIDTH-1:0] i_wr_data,
    input wire [LW-1:0] i_rd_level,
    output wire [WIDTH-1:0] o_rd_data
);
    reg [WIDTH-1:0] mem_q [1:LEVELS];
    integer k;
    always @(posedge i_clock) begin
        if (!i_rstn) begin
            for (k = 1; k <= LEVELS; k = k + 1) begin
                mem_q[k] <= {WIDTH{1'b0}};
            end
        end else if (i_wr_en && i_wr_level != {LW{1'b0}} && i_wr_level <= LEVELS) begin
            mem_q[i_wr_level] <= i_wr_data;
        end
    end
    // Copy selected by the current trap level
    assign o_rd_data = (i_rd_level != {LW{1'b0}} && i_rd_level <= LEVELS) ?
        mem_q[i_rd_level] : {WIDTH{1'b0}};
endmodule // srd_trap_stack

// ===== sim/srd_chk.sv
// Concurrent checks on the state register read decoder ports
`timescale 1ns/1ps
module srd_chk (
    input wire i_clock,
    input wire i_rstn,
    input wire i_valid,
    input wire i_is_priv_read,
    input wire [31:0] i_instr,
    input wire o_ready,
    input wire i_priv,
    input wire i_addr_mask_32_bit,
    input wire i_fp_busy,
    input wire [63:0] i_pc,
    input wire o_wb_en,
    input wire o_barrier,
    input wire [63:0] o_wb_data,
    input wire [2:0] o_exception
);
    wire tk = i_valid && o_ready;
    wire p = i_is_priv_read;
    wire [4:0] sel = i_instr[18:14];
    wire lz = i_instr[13:0] == 14'h0000;
    wire bar = !p && sel == 5'h0F && i_instr[29:25] == 5'h00;
    wire [31:0] pc_lo = i_pc[31:0];
    wire rsv = sel inside {5'h01, [5'h07:5'h0E], 5'h12, 5'h14, 5'h15, 5'h1A, 5'h1B};
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rstn);
    a_low_bits_ill: assert property (tk && !lz && !bar && (!p || i_priv)
        |=> o_exception == 3'h1)
        else $error("nonzero low bits not refused");
    a_user_pr_opc: assert property (tk && p && !i_priv |=> o_exception == 3'h2)
        else $error("user privileged read not refused");
    a_pr_reserved: assert property (tk && p && i_priv && (sel == 5'h0F || sel > 5'h10)
        |=> o_exception == 3'h1)
        else $error("reserved privileged select not refused");
    a_anc_reserved: assert property (tk && !p && rsv |=> o_exception == 3'h1)
        else $error("reserved select not refused");
    a_barrier_out: assert property (tk && bar |=> o_barrier && !o_wb_en)
        else $error("barrier not signalled");
    a_pc_mask: assert property (tk && !p && sel == 5'h05 && lz
        |=> o_wb_en && o_wb_data ==
        ($past(i_addr_mask_32_bit) ? {32'h00000000, $past(pc_lo)} : $past(i_pc)))
        else $error("program counter value wrong");
    a_fp_stall: assert property (i_valid && !p && sel == 5'h06 && lz && i_fp_busy
        |-> !o_ready)
        else $error("fp status read not stalled");
    a_one_result: assert property ($onehot0({o_wb_en, o_barrier, o_exception != 3'h0}))
        else $error("more than one result at once");
    a_data_held: assert property (o_exception != 3'h0 |-> $stable(o_wb_data))
        else $error("write-back data changed on exception");
    c_priv_read: cover property (tk && p && i_priv);
    c_barrier: cover property (o_barrier);
    c_fp_stall: cover property (i_valid && !o_ready);
endmodule // srd_chk
bind srd_state_read srd_chk chk (.*);

// ===== sim/srd_fp_model.sv
// Pipeline side model: floating-point operations pending for a chosen time
`timescale 1ns/1ps
module srd_fp_model (
    input wire logic i_clock,
    input wire logic i_rstn,
    input wire logic i_start,
    input wire logic [3:0] i_len,
    output logic o_busy
);
    logic [3:0] cnt_q;
    always @(posedge i_clock) begin
        if (!i_rstn) cnt_q <= 4'h0;
        else if (i_start) cnt_q <= i_len;
        else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    end
    assign o_busy = cnt_q != 4'h0;
endmodule // srd_fp_model

// ===== sim/tb.sv
// Testbench for the state register read decoder
`timescale 1ns/1ps
module tb;
    logic i_clock = 0, i_rstn = 0, i_valid = 0, i_is_priv_read = 0, i_priv = 0;
    logic i_addr_mask_32_bit = 0, i_fp_enable_pstate = 0, i_fp_enable_fprs = 0;
    logic i_fpu_present = 0, i_cycle_user_off = 0, i_system_user_off = 0, i_perf_ctl_priv = 0;
    logic i_trap_wr = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
    logic fp_start = 0;
    logic [3:0] fp_len = 4'h0, i_wstrb = 4'hF;
    logic [2:0] i_trap_level = 3'h0, i_trap_wr_level = 3'h0;
    logic [31:0] i_instr = 32'h0, i_wdata = 32'h0;
    logic [7:0] i_awaddr = 8'h00, i_araddr = 8'h00;
    logic [63:0] i_mulhi = 0, i_ccr = 0, i_asi = 0, i_cycle = 0, i_pc = 0, i_fprs = 0;
    logic [63:0] i_perf_ctl = 0, i_perf_cnt = 0, i_gsr = 0, i_soft_int = 0, i_system = 0;
    logic [63:0] i_cycle_compare_reg = 0, i_system_compare_reg = 0, i_pr_other = 0;
    logic [63:0] i_trap_saved_pc = 0, i_trap_saved_next_pc = 0;
    logic [63:0] i_trap_saved_state = 0, i_trap_type_reg = 0;
    wire i_fp_busy, o_ready, o_wb_en, o_barrier, o_irq, o_awready, o_wready, o_bvalid;
    wire o_arready, o_rvalid;
    wire [4:0] o_wb_reg;
    wire [63:0] o_wb_data;
    wire [2:0] o_exception;
    wire [1:0] o_bresp, o_rresp;
    wire [31:0] o_rdata;
    logic [63:0] seed = 64'h00000000000069AF;
    logic [63:0] tsv [1:2][0:3];
    logic [73:0] iq[$], rq[$];
    logic [2:0] ctl = 3'h1;
    logic [3:0] stat = 4'h0;
    int miscompares = 0, cmp_count = 0, k = 0, cyc = 0, wbn = 0;
    srd_state_read #(.LEVELS(2), .LW(3)) dut (.*);
    srd_fp_model fp (.i_clock(i_clock), .i_rstn(i_rstn), .i_start(fp_start), .i_len(fp_len),
        .o_busy(i_fp_busy));
    initial begin
        forever #20 i_clock = ~i_clock;
    end
    ////////////////////////////////////////////////////////////////////////////
    function automatic [63:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 7;
        seed ^= seed << 17;
        return seed;
    endfunction
    function automatic [73:0] expect_res(input logic p, input logic [31:0] ins);
        logic [4:0] s;
        logic [2:0] x;
        logic [63:0] d;
        s = ins[18:14];
        x = 3'h0;
        d = 64'h0;
        if (p) begin
            if (!i_priv) x = 3'h2;
            else if (ins[13:0] != 14'h0 || s == 5'h0F || s > 5'h10) x = 3'h1;
            else if (s < 5'h04 && i_trap_level == 3'h0) x = 3'h1;
            else if (s >= 5'h04) d = i_pr_other;
            else if (i_trap_level inside {3'h1, 3'h2}) d = tsv[i_trap_level][s];
        end else begin
            if (s == 5'h0F ? ins[29:25] != 5'h0 : ins[13:0] != 14'h0) x = 3'h1;
            else if (s inside {5'h01, [5'h07:5'h0E], 5'h12, 5'h14, 5'h15, 5'h1A, 5'h1B})
                x = 3'h1;
            else if (s > 5'h1B && ctl[1]) x = 3'h1;
            else if (!i_priv && (s inside {5'h10, 5'h16, 5'h17, 5'h19} || (s > 5'h1B && ctl[2])))
                x = 3'h2;
            else if (s == 5'h13 && !(i_fp_enable_pstate && i_fp_enable_fprs && i_fpu_present))
                x = 3'h3;
            else if (!i_priv && ((s == 5'h04 && i_cycle_user_off) || (s == 5'h18 &&
                i_system_user_off) || (s == 5'h11 && i_perf_ctl_priv))) x = 3'h4;
            else case (s)
                5'h00: d = i_mulhi;
                5'h02: d = i_ccr;
                5'h03: d = i_asi;
                5'h04: d = i_cycle;
                5'h05: d = i_addr_mask_32_bit ? {32'h00000000, i_pc[31:0]} : i_pc;
                5'h06: d = i_fprs;
                5'h10: d = i_perf_ctl;
                5'h11: d = i_perf_cnt;
                5'h13: d = i_gsr;
                5'h16: d = i_soft_int;
                5'h17: d = i_cycle_compare_reg;
                5'h18: d = i_system;
                5'h19: d = i_system_compare_reg;
                default: ;
            endcase
        end
        if (x != 3'h0) return {x, 71'h0};
        if (!p && s == 5'h0F) return {3'h0, 2'h2, 69'h0};
        return {3'h0, 2'h1, ins[29:25], d};
    endfunction
    task automatic cmp(input string n, input logic [73:0] e, input logic [73:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic issue(input logic p, input logic [31:0] ins);
        logic [73:0] e;
        i_valid <= 1;
        i_is_priv_read <= p;
        i_instr <= ins;
        k = 0;
        do begin
            @(posedge i_clock);
            k++;
        end while (!o_ready && k < 200);
        i_valid <= 0;
        e = expect_res(p, ins);
        if (e[69]) wbn++;
        if (e[73:71] != 3'h0) stat |= 4'h1 << (e[73:71] - 3'h1);
        iq.push_back(e);
    endtask
    task automatic run(input int n);
        logic [63:0] r;
        repeat (n) begin
            r = rnd();
            {i_priv, i_addr_mask_32_bit, i_fp_enable_pstate, i_fp_enable_fprs} <= r[3:0];
            {i_fpu_present, i_cycle_user_off, i_system_user_off, i_perf_ctl_priv} <= r[7:4];
            i_trap_level <= {1'b0, r[9:8]};
            {i_mulhi, i_ccr, i_asi, i_cycle, i_pc} <= {rnd(), rnd(), rnd(), rnd(), rnd()};
            {i_fprs, i_perf_ctl, i_perf_cnt, i_gsr, i_soft_int} <=
                {rnd(), rnd(), rnd(), rnd(), rnd()};
            {i_system, i_cycle_compare_reg, i_system_compare_reg, i_pr_other} <=
                {rnd(), rnd(), rnd(), rnd()};
            @(posedge i_clock);
            issue(r[10], r[12:11] == 2'h0 ? r[63:32] : {r[63:46], 14'h0});
        end
        @(posedge i_clock);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1;
        i_wvalid <= 1;
        i_bready <= 1;
        n = 0;
        do begin
            @(posedge i_clock);
            if (i_awvalid && o_awready) i_awvalid <= 0;
            if (i_wvalid && o_wready) i_wvalid <= 0;
            n++;
        end while (!o_bvalid && n < 100);
        i_bready <= 0;
        cmp("bresp", 74'h0, {72'h0, o_bresp});
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [33:0] e);
        int n;
        rq.push_back({40'h0, e});
        i_araddr <= a;
        i_arvalid <= 1;
        i_rready <= 1;
        n = 0;
        do begin
            @(posedge i_clock);
            if (i_arvalid && o_arready) i_arvalid <= 0;
            n++;
        end while (!o_rvalid && n < 100);
        i_rready <= 0;
        @(posedge i_clock);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge i_clock) begin
        cyc++;
        if (cyc == 30000) begin
            miscompares++;
            finish_test();
        end
        if (i_rstn && (o_wb_en || o_barrier || o_exception != 3'h0))
            cmp("result", iq.pop_front(), {o_exception, o_barrier, o_wb_en,
                o_wb_en ? {o_wb_reg, o_wb_data} : 69'h0});
        if (i_rstn && o_rvalid && i_rready)
            cmp("rdata", rq.pop_front(), {40'h0, o_rresp, o_rdata});
    end
    initial begin
        repeat (2) @(posedge i_clock);
        i_rstn <= 1;
        @(posedge i_clock);
        cmp("idle", 74'h6, {71'h0, o_ready, o_awready, o_bvalid});
        for (int lv = 1; lv <= 2; lv++) begin
            tsv[lv] = '{rnd(), rnd(), rnd(), rnd()};
            i_trap_wr <= 1;
            i_trap_wr_level <= 3'(lv);
            i_trap_saved_pc <= tsv[lv][0];
            i_trap_saved_next_pc <= tsv[lv][1];
            i_trap_saved_state <= tsv[lv][2];
            i_trap_type_reg <= tsv[lv][3];
            @(posedge i_clock);
        end
        i_trap_wr <= 0;
        run(400);
        $display("random decode done");
        fp_len <= 4'h6;
        fp_start <= 1;
        @(posedge i_clock);
        fp_start <= 0;
        issue(0, 32'h02018000);
        cmp("fp_wait", 74'(fp_len) + 74'h1, 74'(k));
        @(posedge i_clock);
        issue(0, 32'h0003C00F);
        @(posedge i_clock);
        issue(0, 32'h0203C000);
        $display("fp stall done");
        ctl = 3'h5;
        axi_wr(8'h00, 32'h00000005);
        run(80);
        ctl = 3'h3;
        axi_wr(8'h00, 32'h00000003);
        run(80);
        axi_rd(8'h04, {30'h0, stat});
        cmp("irq_masked", 74'h0, {73'h0, o_irq});
        axi_wr(8'h08, 32'h0000000F);
        @(posedge i_clock);
        cmp("irq", {73'h0, stat != 4'h0}, {73'h0, o_irq});
        axi_wr(8'h04, {28'h0, stat});
        axi_rd(8'h04, 34'h0);
        cmp("irq_clear", 74'h0, {73'h0, o_irq});
        axi_rd(8'h40, {2'h2, 32'h0});
        axi_rd(8'h0C, {18'h00001, 16'(wbn)});
        axi_wr(8'h00, 32'h00000000);
        cmp("ready_off", 74'h0, {73'h0, o_ready});
        $display("register access done");
        repeat (3) @(posedge i_clock);
        cmp("pending", 74'h0, 74'(iq.size() + rq.size()));
        finish_test();
    end
endmodule // tb
